// [rtl/sssc_ctrl.sv]
`include "sssc_defs.svh"
module sssc_ctrl (
    // clock and well resets
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic resume_well_reset_n,
    input wire logic deep_well_power_good,
    input wire logic clock_well_reset_n,
    // state requests from the power controller (same clock)
    input wire sssc_pkg::sssc_state_t sys_state,
    input wire logic s0i3_criteria_met,
    input wire sssc_pkg::sssc_me_t engine_state,
    input wire logic wake_ack_request,
    // straps and configuration
    input wire logic deep_sleep_supported,
    input wire logic engine_on_in_sleep,
    input wire logic early_gate_high_en,
    input wire logic gate_native_mode,
    // pins
    output logic idle_state_indication_n,
    output logic cpu_deep_idle_gate_n,
    output logic sleep4_indication_n,
    output logic sleep5_indication_n,
    output logic aux_sleep_indication_n,
    output logic ac_power_present_o,
    output logic ac_power_present_oe,
    output logic suspend_powerdown_ack,
    output logic suspend_warning_n,
    output logic suspend_warn_mode
);
    import sssc_pkg::*;
    // well resets are asserted asynchronously and released through synchronisers
    sssc_sync_if prim_if ();
    sssc_sync_if dsw_if ();
    sssc_sync_if rtc_if ();
    assign prim_if.raw = resume_well_reset_n & rst_n;
    assign dsw_if.raw = deep_well_power_good & rst_n;
    assign rtc_if.raw = clock_well_reset_n & rst_n;
    sssc_sync u_prim_sync (.clk(sys_clk), .rst_n(prim_if.raw), .s(prim_if));
    sssc_sync u_dsw_sync (.clk(sys_clk), .rst_n(dsw_if.raw), .s(dsw_if));
    sssc_sync u_rtc_sync (.clk(sys_clk), .rst_n(rtc_if.raw), .s(rtc_if));
    logic prim_rst_n;
    logic dsw_rst_n;
    logic rtc_rst_n;
    assign prim_rst_n = prim_if.clean;
    assign dsw_rst_n = dsw_if.clean;
    assign rtc_rst_n = rtc_if.clean;

    // settle counter: dsw pads stay low until the buffer supply is stable
    logic [3:0] settle_reg;
    logic settled;
    assign settled = (settle_reg == `SSSC_SETTLE_CYC);
    always_ff @(posedge sys_clk or negedge dsw_rst_n) begin
        if (!dsw_rst_n) begin
            settle_reg <= 4'h0;
        end else if (!settled) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end

    // deep-sleep-well sleep indications
    logic sleep4_next;
    logic sleep5_next;
    logic aux_next;
    always_comb begin
        sleep4_next = sleep4_indication_n;
        sleep5_next = sleep5_indication_n;
        aux_next = aux_sleep_indication_n;
        case (sys_state)
            SSSC_S0, SSSC_S0I3: begin
                sleep4_next = 1'b1;
                sleep5_next = 1'b1;
                aux_next = 1'b1;
            end
            SSSC_S3: begin
                sleep4_next = 1'b1;
                sleep5_next = 1'b1;
                aux_next = engine_on_in_sleep;
            end
            SSSC_S4: begin
                sleep4_next = 1'b0;
                sleep5_next = 1'b1;
                aux_next = engine_on_in_sleep;
            end
            SSSC_S5: begin
                sleep4_next = 1'b0;
                sleep5_next = 1'b0;
                aux_next = engine_on_in_sleep;
            end
            SSSC_DEEP: begin
                // hold sleep4 and sleep5 as driven before entry; aux follows engine_on_in_sleep
                sleep4_next = sleep4_indication_n;
                sleep5_next = sleep5_indication_n;
                aux_next = engine_on_in_sleep;
            end
            default: begin
                sleep4_next = sleep4_indication_n;
                sleep5_next = sleep5_indication_n;
                aux_next = aux_sleep_indication_n;
            end
        endcase
        if (!settled) begin
            // only low pulse allowed: while the pad supply settles
            sleep4_next = 1'b0;
            sleep5_next = 1'b0;
            aux_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge dsw_rst_n) begin
        if (!dsw_rst_n) begin
            sleep4_indication_n <= 1'b0;
            sleep5_indication_n <= 1'b0;
            aux_sleep_indication_n <= 1'b0;
        end else begin
            sleep4_indication_n <= sleep4_next;
            sleep5_indication_n <= sleep5_next;
            aux_sleep_indication_n <= aux_next;
        end
    end

    // ac present pad: drive low in reset without deep sleep support; with it, only in the first cycle after clock-well release.
    // the strap is caught by the always-on clock-well logic after its release.
    logic deep_strap_reg;
    always_ff @(posedge sys_clk or negedge rtc_rst_n) begin
        if (!rtc_rst_n) begin
            deep_strap_reg <= 1'b0;
        end else begin
            deep_strap_reg <= deep_sleep_supported;
        end
    end
    always_ff @(posedge sys_clk or negedge rtc_rst_n) begin
        if (!rtc_rst_n) begin
            ac_power_present_o <= 1'b0;
            ac_power_present_oe <= 1'b0;
        end else begin
            ac_power_present_o <= 1'b0;
            ac_power_present_oe <= !dsw_rst_n && !deep_strap_reg;
        end
    end

    // primary-well indications
    logic idle_next;
    always_comb begin
        idle_next = 1'b1;
        if (sys_state == SSSC_S0I3 && s0i3_criteria_met) begin
            idle_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge prim_rst_n) begin
        if (!prim_rst_n) begin
            idle_state_indication_n <= 1'b1;
        end else begin
            idle_state_indication_n <= idle_next;
        end
    end
    always_ff @(posedge sys_clk or negedge prim_rst_n) begin
        if (!prim_rst_n) begin
            cpu_deep_idle_gate_n <= 1'b1;
        end else if (gate_native_mode) begin
            cpu_deep_idle_gate_n <= idle_next;
        end else if (early_gate_high_en) begin
            cpu_deep_idle_gate_n <= 1'b1;
        end else begin
            cpu_deep_idle_gate_n <= 1'b0;
        end
    end

    // shared suspend pin: boots after the first one use warning mode while the deep-sleep strap is set
    logic booted_reg;
    always_ff @(posedge sys_clk or negedge rtc_rst_n) begin
        if (!rtc_rst_n) begin
            booted_reg <= 1'b0;
        end else if (prim_rst_n) begin
            booted_reg <= 1'b1;
        end
    end
    // the pin function is chosen once per boot, at the first primary-well edge
    logic mode_taken_reg;
    always_ff @(posedge sys_clk or negedge prim_rst_n) begin
        if (!prim_rst_n) begin
            mode_taken_reg <= 1'b0;
        end else begin
            mode_taken_reg <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge prim_rst_n) begin
        if (!prim_rst_n) begin
            suspend_warn_mode <= 1'b0;
        end else if (!mode_taken_reg) begin
            // a strap change mid-boot must not flip the pin function under the board
            suspend_warn_mode <= booted_reg && deep_strap_reg;
        end
    end
    always_ff @(posedge sys_clk or negedge prim_rst_n) begin
        if (!prim_rst_n) begin
            suspend_powerdown_ack <= 1'b0;
            suspend_warning_n <= 1'b1;
        end else begin
            suspend_powerdown_ack <= !suspend_warn_mode && engine_state == SSSC_ME_OFF_T
                && wake_ack_request;
            suspend_warning_n <= !(suspend_warn_mode && sys_state != SSSC_S0
                && sys_state != SSSC_S0I3);
        end
    end

    // checks
    AST_IDLE_S0I3: assert property (@(posedge sys_clk) disable iff (!prim_rst_n)
        sys_state == SSSC_S0I3 && s0i3_criteria_met |=> !idle_state_indication_n)
        else $error("idle indication not low in s0i3");
    AST_IDLE_S0: assert property (@(posedge sys_clk) disable iff (!prim_rst_n)
        sys_state == SSSC_S0 |=> idle_state_indication_n)
        else $error("idle indication not high in s0");
    AST_S4_LEVEL: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settled && sys_state == SSSC_S3 |=> sleep4_indication_n)
        else $error("sleep4 not high in s3");
    AST_S5_LOW: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settled && sys_state == SSSC_S5 |=> !sleep5_indication_n && !sleep4_indication_n)
        else $error("sleep5 not low in s5");
    AST_DEEP_HOLD: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settled && sys_state == SSSC_DEEP |=> $stable(sleep4_indication_n)
        && $stable(sleep5_indication_n))
        else $error("sleep levels moved in deep sleep");
    AST_AC_DRIVE: assert property (@(posedge sys_clk) disable iff (!rtc_rst_n)
        !dsw_rst_n && !deep_strap_reg |=> ac_power_present_oe && !ac_power_present_o)
        else $error("ac present not driven low in reset");
    AST_MODE_HOLD: assert property (@(posedge sys_clk) disable iff (!prim_rst_n)
        mode_taken_reg |=> $stable(suspend_warn_mode))
        else $error("suspend pin function changed within a boot");
    AST_ACK_ZERO: assert property (@(posedge sys_clk) disable iff (!prim_rst_n)
        engine_state != SSSC_ME_OFF_T |=> !suspend_powerdown_ack)
        else $error("ack set with engine on");
    sequence settle_seq;
        !settled ##1 settled;
    endsequence
    AST_NO_GLITCH: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settled && sleep5_indication_n && sys_state != SSSC_S5 |=> sleep5_indication_n)
        else $error("sleep5 glitched low");
    AST_SETTLE_LEN: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settle_seq |-> $past(settle_reg) == `SSSC_SETTLE_CYC - 4'h1)
        else $error("settle window wrong length");
    AST_AUX_CFG: assert property (@(posedge sys_clk) disable iff (!dsw_rst_n)
        settled && sys_state == SSSC_S5 |=> aux_sleep_indication_n == $past(engine_on_in_sleep))
        else $error("aux sleep not per configuration");
    AST_GATE_NATIVE: assert property (@(posedge sys_clk) disable iff (!prim_rst_n)
        !gate_native_mode && early_gate_high_en |=> cpu_deep_idle_gate_n)
        else $error("gate not high before native mode");
endmodule : sssc_ctrl

// [pkg/sssc_defs.svh]
`ifndef SSSC_DEFS_SVH
`define SSSC_DEFS_SVH
// system power state codes on sys_state
`define SSSC_ST_S0 3'h0
`define SSSC_ST_S0I3 3'h1
`define SSSC_ST_S3 3'h2
`define SSSC_ST_S4 3'h3
`define SSSC_ST_S5 3'h4
`define SSSC_ST_DEEP 3'h5
// management engine state codes
`define SSSC_ME_ON 2'h0
`define SSSC_ME_LOWPWR 2'h1
`define SSSC_ME_OFF 2'h2
// cycles a pad is held low after its well reset releases
`define SSSC_SETTLE_CYC 4'h4
`endif

// [pkg/sssc_pkg.sv]
package sssc_pkg;
    typedef enum logic [2:0] {
        SSSC_S0 = 3'b000,
        SSSC_S0I3 = 3'b001,
        SSSC_S3 = 3'b010,
        SSSC_S4 = 3'b011,
        SSSC_S5 = 3'b100,
        SSSC_DEEP = 3'b101
    } sssc_state_t;
    typedef enum logic [1:0] {
        SSSC_ME_ON_T = 2'b00,
        SSSC_ME_LP_T = 2'b01,
        SSSC_ME_OFF_T = 2'b10
    } sssc_me_t;
endpackage : sssc_pkg

// [pkg/sssc_sync_if.sv]
interface sssc_sync_if;
    logic raw;
    logic clean;
    modport src (output raw, input clean);
    modport dst (input raw, output clean);
endinterface : sssc_sync_if

// [rtl/sssc_sync.sv]
// three-stage synchroniser; output moves when stages two and three agree
module sssc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // signal
    sssc_sync_if.dst s
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic clean_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= s.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clean_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            clean_reg <= s3_reg;
        end
    end
    assign s.clean = clean_reg;
endmodule : sssc_sync

// [test/sssc_board_model.sv]
module sssc_board_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // supply enables from the bench
    input wire logic deep_on,
    input wire logic primary_on,
    // well resets and power good
    output logic clock_well_reset_n,
    output logic deep_well_power_good,
    output logic resume_well_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] deep_ramp_reg;
    logic [1:0] prim_ramp_reg;
    // regulators take two cycles to ramp; primary only follows a good deep well
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_well_reset_n <= 1'b0;
            deep_ramp_reg <= 2'h0;
            prim_ramp_reg <= 2'h0;
        end else begin
            clock_well_reset_n <= 1'b1;
            deep_ramp_reg <= {deep_ramp_reg[0], deep_on};
            prim_ramp_reg <= {prim_ramp_reg[0], primary_on & deep_ramp_reg[1]};
        end
    end
    assign deep_well_power_good = deep_ramp_reg[1];
    assign resume_well_reset_n = prim_ramp_reg[1];
endmodule : sssc_board_model

// [test/sleep_signal_state_control_bench.sv]
module sleep_signal_state_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sssc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic deep_on = 1'b0;
    logic primary_on = 1'b0;
    logic rw_n, dw_pg, cw_n, crit = 1'b0, wake = 1'b0, strap = 1'b0;
    logic eois = 1'b0, early = 1'b0, native = 1'b1;
    sssc_state_t sys_state = SSSC_S0;
    sssc_me_t eng = SSSC_ME_ON_T;
    logic idle_n, gate_n, s4_n, s5_n, aux_n, ac_o, ac_oe, ack, warn_n, warn_mode;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    sssc_board_model board_u (.sys_clk(sys_clk), .rst_n(rst_n), .deep_on(deep_on),
        .primary_on(primary_on), .clock_well_reset_n(cw_n),
        .deep_well_power_good(dw_pg), .resume_well_reset_n(rw_n));
    sssc_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .resume_well_reset_n(rw_n),
        .deep_well_power_good(dw_pg), .clock_well_reset_n(cw_n), .sys_state(sys_state),
        .s0i3_criteria_met(crit), .engine_state(eng), .wake_ack_request(wake),
        .deep_sleep_supported(strap), .engine_on_in_sleep(eois), .early_gate_high_en(early),
        .gate_native_mode(native), .idle_state_indication_n(idle_n),
        .cpu_deep_idle_gate_n(gate_n), .sleep4_indication_n(s4_n),
        .sleep5_indication_n(s5_n), .aux_sleep_indication_n(aux_n),
        .ac_power_present_o(ac_o), .ac_power_present_oe(ac_oe),
        .suspend_powerdown_ack(ack), .suspend_warning_n(warn_n),
        .suspend_warn_mode(warn_mode));
    always #10 sys_clk = ~sys_clk;
    task results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // the whole run needs well under 1000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("mismatch timeout expected done seen hang");
            results();
        end
    end
    task chk(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    task go(input sssc_state_t s);
        @(posedge sys_clk);
        sys_state <= s;
        wait_cyc(3);
    endtask : go
    task test_reset();
        wait_cyc(8);
        chk("ac_oe", 1'b1, ac_oe);
        chk("ac_o", 1'b0, ac_o);
        chk("s4_rst", 1'b0, s4_n);
        chk("s5_rst", 1'b0, s5_n);
        chk("aux_rst", 1'b0, aux_n);
        chk("idle_rst", 1'b1, idle_n);
        chk("gate_rst", 1'b1, gate_n);
        chk("ack_rst", 1'b0, ack);
        chk("warn_rst", 1'b1, warn_n);
        deep_on <= 1'b1;
        wait_cyc(5);
        chk("s4_settle", 1'b0, s4_n);
        wait_cyc(12);
        chk("ac_oe_off", 1'b0, ac_oe);
        chk("s4_up", 1'b1, s4_n);
        primary_on <= 1'b1;
        wait_cyc(12);
        chk("warn_mode_first", 1'b0, warn_mode);
        $display("test reset done");
    endtask : test_reset
    task automatic test_states();
        sssc_state_t st[4] = '{SSSC_S0, SSSC_S3, SSSC_S4, SSSC_S5};
        logic [3:0] e4 = 4'hC;
        logic [3:0] e5 = 4'hE;
        for (int i = 0; i < 4; i++) begin
            go(st[i]);
            chk("s4", e4[3 - i], s4_n);
            chk("s5", e5[3 - i], s5_n);
        end
        crit <= 1'b1;
        go(SSSC_S0I3);
        chk("idle_s0i3", 1'b0, idle_n);
        chk("gate_s0i3", 1'b0, gate_n);
        go(SSSC_S0);
        chk("idle_s0", 1'b1, idle_n);
        chk("gate_s0", 1'b1, gate_n);
        $display("test states done");
    endtask : test_states
    task test_deep();
        go(SSSC_S3);
        go(SSSC_DEEP);
        chk("s4_deep3", 1'b1, s4_n);
        chk("s5_deep3", 1'b1, s5_n);
        go(SSSC_S4);
        go(SSSC_DEEP);
        chk("s4_deep4", 1'b0, s4_n);
        chk("s5_deep4", 1'b1, s5_n);
        $display("test deep done");
    endtask : test_deep
    task test_engine();
        wake <= 1'b1;
        eng <= SSSC_ME_ON_T;
        go(SSSC_S5);
        chk("ack_on", 1'b0, ack);
        eng <= SSSC_ME_LP_T;
        eois <= 1'b1;
        wait_cyc(3);
        chk("ack_lp", 1'b0, ack);
        chk("aux_on", 1'b1, aux_n);
        eng <= SSSC_ME_OFF_T;
        eois <= 1'b0;
        wait_cyc(3);
        chk("ack_off", 1'b1, ack);
        chk("aux_off", 1'b0, aux_n);
        wake <= 1'b0;
        wait_cyc(3);
        chk("ack_nowake", 1'b0, ack);
        $display("test engine done");
    endtask : test_engine
    task test_gate();
        native <= 1'b0;
        early <= 1'b1;
        go(SSSC_S0I3);
        chk("gate_early", 1'b1, gate_n);
        early <= 1'b0;
        wait_cyc(3);
        chk("gate_low", 1'b0, gate_n);
        native <= 1'b1;
        $display("test gate done");
    endtask : test_gate
    task test_warn();
        strap <= 1'b1;
        wait_cyc(3);
        chk("warn_mode_hold", 1'b0, warn_mode);
        for (int i = 0; i < 2; i++) begin
            primary_on <= 1'b0;
            wait_cyc(10);
            primary_on <= 1'b1;
            wait_cyc(12);
        end
        chk("warn_mode", 1'b1, warn_mode);
        go(SSSC_S3);
        chk("warn_s3", 1'b0, warn_n);
        go(SSSC_S0);
        chk("warn_s0", 1'b1, warn_n);
        $display("test warn done");
    endtask : test_warn
    initial begin
        wait_cyc(3);
        rst_n <= 1'b1;
        test_reset();
        test_states();
        test_deep();
        test_engine();
        test_gate();
        test_warn();
        results();
    end
endmodule : sleep_signal_state_control_bench
